/* File: design/fsp_pkg.sv */
/*
 * Constants, types and register map of the flash self-programming sequencer.
 * Assumes a 10 MHz core clock and a 16-bit byte pointer from the CPU core.
 */
package fsp_pkg;
	localparam int PTR_W = 16;
	localparam int DATA_W = 16;
	localparam int WORD_BITS = 7;
	localparam int PAGE_W = PTR_W - WORD_BITS - 1;
	localparam int CONC_PAGES = 112;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_MIN_NS = 3_700_000;
	localparam int PROG_MAX_NS = 4_500_000;
	localparam int PROG_MIN_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_MAX_CYC = PROG_MAX_NS / CLK_PERIOD_NS;
	localparam logic [2:0] STORE_WIN = 3'h4;
	localparam logic [2:0] LOAD_WIN = 3'h3;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam int BIT_EN = 0;
	localparam int BIT_REEN = 4;
	localparam int BIT_BUSY = 6;
	localparam int BIT_IE = 7;
	localparam logic [5:0] PAT_LOAD = 6'h01;
	localparam logic [5:0] PAT_ERASE = 6'h03;
	localparam logic [5:0] PAT_WRITE = 6'h05;
	localparam logic [5:0] PAT_LOCK = 6'h09;
	localparam logic [5:0] PAT_REEN = 6'h11;
	localparam logic [5:0] PAT_SIG = 6'h21;
	localparam logic [PTR_W-1:0] PTR_FUSE_LOW = 16'h0000;
	localparam logic [PTR_W-1:0] PTR_LOCK = 16'h0001;
	localparam logic [PTR_W-1:0] PTR_FUSE_EXT = 16'h0002;
	localparam logic [PTR_W-1:0] PTR_FUSE_HIGH = 16'h0003;
	localparam logic [PTR_W-1:0] PTR_SIG1 = 16'h0000;
	localparam logic [PTR_W-1:0] PTR_CAL = 16'h0001;
	localparam logic [PTR_W-1:0] PTR_SIG2 = 16'h0002;
	localparam logic [PTR_W-1:0] PTR_SIG3 = 16'h0004;
	localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
	localparam logic [7:0] LOCK_RESET = 8'hFF;
	localparam logic [1:0] LOCK_KEEP = 2'h3;
	typedef struct packed {
		logic store;
		logic load;
		logic [PTR_W-1:0] ptr;
		logic [DATA_W-1:0] data;
	} fsp_cpu_req_t;
	typedef struct packed {
		logic start;
		logic erase;
		logic write;
		logic [PAGE_W-1:0] page;
	} fsp_flash_op_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} fsp_state_t;
	typedef enum logic [2:0] {
		OP_NONE, OP_LOAD, OP_ERASE, OP_WRITE, OP_LOCK, OP_REEN, OP_SIG
	} fsp_op_t;
endpackage

/* File: design/fsp_flash_self_programming.sv */
/*
 * Flash self-programming sequencer: control register on AHB-Lite, CPU
 * store/load strobes, temporary page buffer, lock bits, fuse and signature
 * readback, operation timer. Assumes CPU and EEPROM control share core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_self_programming import fsp_pkg::*; #(
	parameter int PAGE_WORDS = 128,
	parameter int PROG_CYCLES = PROG_MIN_CYC,
	parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'hA5, // arbitrary value
	parameter logic [7:0] SIG_BYTE3 = 8'h3C // arbitrary value
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire fsp_cpu_req_t cpuReq,
	input wire logic eepromBusy,
	input wire logic [7:0] fuseLow,
	input wire logic [7:0] fuseHigh,
	input wire logic [7:0] fuseExt,
	input wire logic [7:0] calByte,
	input wire logic [WORD_BITS-1:0] flashRdIdx,
	output logic [DATA_W-1:0] flashRdData,
	output fsp_flash_op_t flashOp,
	output logic cpuHalt,
	output logic concReadBlock,
	output logic lpmValid,
	output logic [7:0] lpmData,
	output logic spmIrq
);
	fsp_state_t state;
	fsp_op_t opKind;
	logic [2:0] age;
	logic [31:0] progCnt;
	logic ieBit;
	logic concBusy;
	logic opConc;
	logic wrPend;
	logic [7:0] wrAddr;
	logic eeBusyQ;
	logic [7:0] lockBits;
	logic [DATA_W-1:0] pageBuf [PAGE_WORDS];
	logic ctrlWr;
	logic cmdOk;
	logic enBit;
	logic storeHit;
	logic loadHit;
	logic [2:0] winLimit;
	logic [WORD_BITS-1:0] reqWord;
	logic [PAGE_W-1:0] reqPage;
	logic reqConc;
	logic [5:0] cmdBits;
	fsp_op_t next_op;

	// pointer split into word-in-page and page fields
	assign reqWord = cpuReq.ptr[WORD_BITS:1];
	assign reqPage = cpuReq.ptr[PTR_W-1:WORD_BITS+1];
	assign reqConc = (32'(reqPage) < CONC_PAGES);
	assign ctrlWr = wrPend && (wrAddr == CTRL_OFS);
	assign enBit = (state != ST_IDLE);
	assign winLimit = (opKind == OP_SIG) ? LOAD_WIN : STORE_WIN;
	// store and load are taken only inside their windows
	assign storeHit = (state == ST_ARMED) && cpuReq.store && (age < STORE_WIN)
		&& (opKind != OP_SIG);
	assign loadHit = (state == ST_ARMED) && cpuReq.load && (age < LOAD_WIN)
		&& ((opKind == OP_LOCK) || (opKind == OP_SIG)) && !eepromBusy;

	// command pattern decode of the written control byte
	always_comb begin
		next_op = OP_NONE;
		if (hwdata[5:0] == PAT_LOAD) begin
			next_op = OP_LOAD;
		end else if (hwdata[5:0] == PAT_ERASE) begin
			next_op = OP_ERASE;
		end else if (hwdata[5:0] == PAT_WRITE) begin
			next_op = OP_WRITE;
		end else if (hwdata[5:0] == PAT_LOCK) begin
			next_op = OP_LOCK;
		end else if (hwdata[5:0] == PAT_REEN) begin
			next_op = OP_REEN;
		end else if (hwdata[5:0] == PAT_SIG) begin
			next_op = OP_SIG;
		end
	end
	assign cmdOk = (next_op != OP_NONE) && !eepromBusy;

	// command bits shown while armed or running
	always_comb begin
		cmdBits = 6'h00;
		case (opKind)
			OP_LOAD: cmdBits = PAT_LOAD;
			OP_ERASE: cmdBits = PAT_ERASE;
			OP_WRITE: cmdBits = PAT_WRITE;
			OP_LOCK: cmdBits = PAT_LOCK;
			OP_REEN: cmdBits = PAT_REEN;
			OP_SIG: cmdBits = PAT_SIG;
			default: cmdBits = 6'h00;
		endcase
		if (!enBit) begin
			cmdBits = 6'h00;
		end
	end

	// ahb-lite slave: zero wait states, always OKAY
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wrPend <= hsel && hready && htrans[1] && hwrite;
			wrAddr <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				if (haddr[7:0] == CTRL_OFS) begin
					hrdata <= {24'h000000, ieBit, concBusy, cmdBits};
				end else if (haddr[7:0] == STAT_OFS) begin
					hrdata <= {29'h0, eepromBusy, cpuHalt, state == ST_RUN};
				end else begin
					hrdata <= 32'h0000_0000;
				end
			end
		end
	end

	// interrupt enable bit, written on any control write
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ieBit <= 1'b0;
		end else if (ctrlWr) begin
			ieBit <= hwdata[BIT_IE];
		end
	end

	// sequencer: arm, window count, timed operation
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			opKind <= OP_NONE;
			age <= 3'h0;
			progCnt <= 32'h0;
			opConc <= 1'b0;
			cpuHalt <= 1'b0;
			flashOp <= '0;
		end else begin
			flashOp.start <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (ctrlWr && cmdOk) begin
						state <= ST_ARMED;
						opKind <= next_op;
						age <= 3'h0;
					end
				end
				ST_ARMED: begin
					age <= age + 3'h1;
					if (storeHit && ((opKind == OP_ERASE) ||
						(opKind == OP_WRITE) || (opKind == OP_LOCK))) begin
						state <= ST_RUN;
						progCnt <= 32'(PROG_CYCLES - 1);
						flashOp.start <= 1'b1;
						flashOp.erase <= (opKind == OP_ERASE);
						flashOp.write <= (opKind == OP_WRITE);
						flashOp.page <= reqPage;
						// lock programming keeps all flash readable
						opConc <= reqConc && (opKind != OP_LOCK);
						cpuHalt <= !reqConc && (opKind != OP_LOCK);
					end else if (storeHit || loadHit) begin
						state <= ST_IDLE;
					end else if (age == winLimit - 3'h1) begin
						state <= ST_IDLE;
					end
				end
				ST_RUN: begin
					progCnt <= progCnt - 32'h1;
					if (progCnt == 32'h0) begin
						state <= ST_IDLE;
						cpuHalt <= 1'b0;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// concurrent-read busy flag and read blocking
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			concBusy <= 1'b0;
			concReadBlock <= 1'b0;
		end else begin
			if (state == ST_RUN && opConc) begin
				concBusy <= 1'b1;
			end else if (storeHit && opKind == OP_REEN) begin
				concBusy <= 1'b0;
			end
			concReadBlock <= (state == ST_RUN && opConc) || concBusy;
		end
	end

	// temporary page buffer
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			eeBusyQ <= 1'b0;
			for (int i = 0; i < PAGE_WORDS; i++) begin
				pageBuf[i] <= ERASED_WORD;
			end
		end else begin
			eeBusyQ <= eepromBusy;
			if ((storeHit && (opKind == OP_WRITE || opKind == OP_REEN)) ||
				(eepromBusy && !eeBusyQ)) begin
				for (int i = 0; i < PAGE_WORDS; i++) begin
					pageBuf[i] <= ERASED_WORD;
				end
			end else if (storeHit && opKind == OP_LOAD) begin
				pageBuf[reqWord] <= cpuReq.data;
			end
		end
	end

	// buffer read port for the flash array during page write
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			flashRdData <= ERASED_WORD;
		end else begin
			flashRdData <= pageBuf[flashRdIdx];
		end
	end

	// lock bits: a cleared source bit in 5:0 programs its lock bit, bits 7:6 are kept
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lockBits <= LOCK_RESET;
		end else if (storeHit && opKind == OP_LOCK) begin
			lockBits <= lockBits & {LOCK_KEEP, cpuReq.data[5:0]};
		end
	end

	// fuse, lock and signature readback
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lpmValid <= 1'b0;
			lpmData <= 8'h00;
		end else begin
			lpmValid <= loadHit;
			if (loadHit && opKind == OP_LOCK) begin
				if (cpuReq.ptr == PTR_LOCK) begin
					lpmData <= lockBits;
				end else if (cpuReq.ptr == PTR_FUSE_LOW) begin
					lpmData <= fuseLow;
				end else if (cpuReq.ptr == PTR_FUSE_HIGH) begin
					lpmData <= fuseHigh;
				end else if (cpuReq.ptr == PTR_FUSE_EXT) begin
					lpmData <= fuseExt;
				end else begin
					lpmData <= 8'hFF;
				end
			end else if (loadHit) begin
				if (cpuReq.ptr == PTR_SIG1) begin
					lpmData <= SIG_BYTE1;
				end else if (cpuReq.ptr == PTR_SIG2) begin
					lpmData <= SIG_BYTE2;
				end else if (cpuReq.ptr == PTR_SIG3) begin
					lpmData <= SIG_BYTE3;
				end else if (cpuReq.ptr == PTR_CAL) begin
					lpmData <= calByte;
				end else begin
					lpmData <= 8'hFF;
				end
			end
		end
	end

	// level interrupt while enable bit is clear
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			spmIrq <= 1'b0;
		end else begin
			spmIrq <= ieBit && !enBit;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_erase_start: assert property (
		storeHit && opKind == OP_ERASE |=> flashOp.start && flashOp.erase)
		else $error("erase did not start after store");
	chk_erase_page: assert property (
		storeHit && opKind == OP_ERASE |=> flashOp.page == $past(reqPage))
		else $error("erase page differs from pointer page field");
	chk_halt_span: assert property (
		storeHit && (opKind == OP_WRITE || opKind == OP_ERASE) && !reqConc
		|=> cpuHalt [*8])
		else $error("cpu not halted during halting-section write");
	chk_buffer_load: assert property (
		storeHit && opKind == OP_LOAD |=>
		pageBuf[$past(reqWord)] == $past(cpuReq.data))
		else $error("page buffer slot not loaded");
	chk_buffer_clear: assert property (
		storeHit && opKind == OP_WRITE |=> pageBuf[0] == ERASED_WORD)
		else $error("buffer not cleared after page write");
	chk_irq_level: assert property (
		ieBit && state == ST_IDLE |=> spmIrq)
		else $error("interrupt missing while enable bit clear");
	chk_conc_block: assert property (
		state == ST_RUN && opConc |=> concReadBlock)
		else $error("concurrent-read section not blocked");
	chk_busy_holds: assert property (
		concBusy && !(storeHit && opKind == OP_REEN) |=> concBusy)
		else $error("busy flag dropped without re-enable");
	chk_eeprom_block: assert property (
		state == ST_IDLE && eepromBusy |=> state == ST_IDLE)
		else $error("command accepted during eeprom write");
	chk_arm_timeout: assert property (
		$rose(state == ST_ARMED) |-> ##[1:4] state != ST_ARMED)
		else $error("access bits did not time out");
	chk_fuse_high: assert property (
		loadHit && opKind == OP_LOCK && cpuReq.ptr == PTR_FUSE_HIGH |=>
		lpmValid && lpmData == $past(fuseHigh))
		else $error("fuse high byte not returned");
	chk_enable_run: assert property (
		state == ST_RUN && progCnt != 32'h0 |=> state == ST_RUN)
		else $error("operation ended before its count");
	// eeprom write start throws away the loaded words
	chk_eeprom_clear: assert property (
		eepromBusy && !eeBusyQ |=> pageBuf[0] == ERASED_WORD)
		else $error("buffer kept after eeprom write start");
	// lock byte returned for the lock pointer
	chk_lock_read: assert property (
		loadHit && opKind == OP_LOCK && cpuReq.ptr == PTR_LOCK |=>
		lpmValid && lpmData == $past(lockBits))
		else $error("lock byte not returned");
	// a completed read drops the access bits
	chk_read_clears: assert property (
		loadHit |=> state == ST_IDLE)
		else $error("access bits kept after read");
	// signature access gives up after its shorter window
	chk_sig_window: assert property (
		state == ST_ARMED && opKind == OP_SIG && age == LOAD_WIN - 3'h1
		|=> state == ST_IDLE)
		else $error("signature access outlived its window");
	// lock programming neither halts nor blocks
	chk_lock_open: assert property (
		state == ST_RUN && !flashOp.erase && !flashOp.write |->
		!cpuHalt && !opConc)
		else $error("flash blocked during lock programming");
	// re-enable frees the section and empties the buffer
	chk_reen_clear: assert property (
		storeHit && opKind == OP_REEN |=>
		!concBusy && pageBuf[0] == ERASED_WORD)
		else $error("re-enable did not clear busy or buffer");
	// cleared source bits 5:0 program their lock bits, bits 7:6 are kept
	chk_lock_program: assert property (
		storeHit && opKind == OP_LOCK |=> lockBits ==
		($past(lockBits) & {LOCK_KEEP, $past(cpuReq.data[5:0])}))
		else $error("lock bits not programmed from source byte");
	// no halt once the sequencer is idle
	chk_halt_clear: assert property (
		state == ST_IDLE |-> !cpuHalt)
		else $error("cpu halted while idle");
	// page write starts on the pointer page
	chk_write_page: assert property (
		storeHit && opKind == OP_WRITE |=> flashOp.start &&
		flashOp.write && flashOp.page == $past(reqPage))
		else $error("page write did not start on its page");
endmodule
`default_nettype wire

/* File: tb/fsp_cpu_model.sv */
/*
 * CPU core model: issues program-store and program-load strobes.
 * Assumes it shares core_clk with the sequencer, no synchroniser.
 */
`timescale 1ns/10ps
`default_nettype none
module fsp_cpu_model import fsp_pkg::*; (
	input wire logic core_clk,
	output var fsp_cpu_req_t cpuReq
);
	// released lines show inverted values, never the last ones
	initial begin
		cpuReq = '0;
	end
	// store after waitCyc idle cycles, strobe held for one edge
	task automatic store(input logic [PTR_W-1:0] p,
		input logic [DATA_W-1:0] d, input int waitCyc);
		repeat (waitCyc) @(posedge core_clk);
		cpuReq.store <= 1'b1;
		cpuReq.ptr <= p;
		cpuReq.data <= d;
		@(posedge core_clk);
		cpuReq.store <= 1'b0;
		cpuReq.ptr <= ~p;
		cpuReq.data <= ~d;
	endtask
	// load after waitCyc idle cycles; result shows after return
	task automatic load(input logic [PTR_W-1:0] p, input int waitCyc);
		repeat (waitCyc) @(posedge core_clk);
		cpuReq.load <= 1'b1;
		cpuReq.ptr <= p;
		@(posedge core_clk);
		cpuReq.load <= 1'b0;
		cpuReq.ptr <= ~p;
	endtask
endmodule
`default_nettype wire

/* File: tb/fsp_flash_self_programming_tb_top.sv */
/*
 * Self-checking bench of the self-programming sequencer.
 * Assumes a shortened operation time and the CPU model beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_self_programming_tb_top import fsp_pkg::*; ;
	localparam int PC = 20;
	localparam logic [31:0] A_CTRL = {24'h0, CTRL_OFS};
	localparam logic [31:0] A_STAT = {24'h0, STAT_OFS};
	localparam logic [7:0] S1 = 8'h1E; // arbitrary value
	localparam logic [7:0] S2 = 8'h2D; // arbitrary value
	localparam logic [7:0] S3 = 8'h4B; // arbitrary value
	logic core_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, eepromBusy = 1'b0, ie = 1'b0;
	logic [WORD_BITS-1:0] flashRdIdx = '0;
	logic [DATA_W-1:0] flashRdData;
	fsp_cpu_req_t cpuReq;
	fsp_flash_op_t flashOp;
	logic cpuHalt, concReadBlock, lpmValid, spmIrq;
	logic [7:0] lpmData;
	int failCount = 0, nChecks = 0;
	// free-running core clock
	always #50 core_clk = ~core_clk;
	fsp_cpu_model cpu (.core_clk(core_clk), .cpuReq(cpuReq));
	fsp_flash_self_programming #(.PROG_CYCLES(PC), .SIG_BYTE1(S1),
		.SIG_BYTE2(S2), .SIG_BYTE3(S3)) dut (.core_clk(core_clk),
		.reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cpuReq(cpuReq), .eepromBusy(eepromBusy),
		.fuseLow(8'h62), .fuseHigh(8'h99), .fuseExt(8'hFD),
		.calByte(8'hA7), .flashRdIdx(flashRdIdx),
		.flashRdData(flashRdData), .flashOp(flashOp), .cpuHalt(cpuHalt),
		.concReadBlock(concReadBlock), .lpmValid(lpmValid),
		.lpmData(lpmData), .spmIrq(spmIrq));
	// verdict and end of run
	task automatic report_and_stop();
		if (failCount == 0 && nChecks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			failCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_up(input logic c);
		if (c) begin
			failCount++;
			report_and_stop();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		give_up(n >= 50);
	endtask
	// one single AHB-Lite word transfer
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(x & m, e);
	endtask
	// control write with pattern, then a store
	task automatic cmd(input logic [5:0] pat, input logic [15:0] p,
		input logic [15:0] d, input int w);
		wr(A_CTRL, {24'h0, ie, 1'b0, pat});
		cpu.store(p, d, w);
	endtask
	task automatic wait_idle();
		logic [31:0] x;
		int n;
		n = 0;
		do begin
			ahb(1'b0, A_CTRL, 32'h0, x);
			n++;
		end while (x[BIT_EN] !== 1'b0 && n < 100);
		give_up(n >= 100);
	endtask
	task automatic slot_chk(input logic [6:0] i, input logic [15:0] e);
		flashRdIdx <= i;
		tick(2);
		#1 chk(flashRdData, e);
	endtask
	// load a slot, then erase a halting-section page
	task automatic t_erase_halt();
		int n;
		slot_chk(7'h05, ERASED_WORD);
		rd_chk(A_CTRL, 32'hFF, 32'h0);
		cmd(PAT_LOAD, 16'h750A, 16'h1234, 3);
		slot_chk(7'h05, 16'h1234);
		cmd(PAT_ERASE, 16'h75FF, 16'hAAAA, 0);
		#1 chk({flashOp.start, flashOp.erase, flashOp.write,
			flashOp.page}, 11'h675);
		rd_chk(A_STAT, 32'h7, 32'h3);
		rd_chk(A_CTRL, 32'h1, 32'h1);
		n = 0;
		while (cpuHalt === 1'b1 && n < 2 * PC) begin
			tick(1);
			n++;
		end
		chk(n > PC - 8 && n < PC, 1);
		wait_idle();
		slot_chk(7'h05, 16'h1234);
	endtask
	// erase and write a concurrent-read page, busy until re-enabled
	task automatic t_write();
		cmd(PAT_ERASE, 16'h0300, 16'h0, 0);
		tick(1);
		#1 chk({cpuHalt, concReadBlock}, 2'b01);
		wait_idle();
		rd_chk(A_CTRL, 32'h41, 32'h40);
		cmd(PAT_REEN, 16'h0, 16'h0, 0);
		rd_chk(A_CTRL, 32'h41, 32'h0);
		slot_chk(7'h05, ERASED_WORD);
		cmd(PAT_LOAD, 16'h0300, 16'hBEEF, 1);
		cmd(PAT_WRITE, 16'h0300, 16'h0, 2);
		#1 chk({flashOp.start, flashOp.erase, flashOp.write,
			flashOp.page}, 11'h503);
		tick(1);
		#1 chk({cpuHalt, concReadBlock}, 2'b01);
		wait_idle();
		chk(concReadBlock, 1'b1);
		slot_chk(7'h00, ERASED_WORD);
		cmd(PAT_REEN, 16'h0, 16'h0, 0);
		tick(1);
		#1 chk(concReadBlock, 1'b0);
	endtask
	// lock programming, lock, fuse and signature readback
	task automatic t_lock_read();
		logic [7:0] e [7];
		logic [15:0] p [7];
		e = '{8'h62, 8'h99, 8'hFD, 8'hA7, S1, S2, S3};
		p = '{PTR_FUSE_LOW, PTR_FUSE_HIGH, PTR_FUSE_EXT, PTR_CAL,
			PTR_SIG1, PTR_SIG2, PTR_SIG3};
		cmd(PAT_LOCK, PTR_LOCK, 16'h00F0, 0);
		#1 chk({flashOp.start, flashOp.erase, flashOp.write}, 3'h4);
		tick(1);
		#1 chk({cpuHalt, concReadBlock}, 2'b00);
		wait_idle();
		wr(A_CTRL, {26'h0, PAT_LOCK});
		cpu.load(PTR_LOCK, 2);
		#1 chk({lpmValid, lpmData}, 9'h1F0);
		rd_chk(A_CTRL, 32'h1, 32'h0);
		for (int i = 0; i < 7; i++) begin
			wr(A_CTRL, {26'h0, i < 3 ? PAT_LOCK : PAT_SIG});
			cpu.load(p[i], i % 3);
			#1 chk({lpmValid, lpmData}, {1'b1, e[i]});
		end
	endtask
	// timeouts, EEPROM blocking, unmapped read
	task automatic t_refuse();
		wr(A_CTRL, {26'h0, PAT_SIG});
		tick(4);
		rd_chk(A_CTRL, 32'h1, 32'h0);
		cpu.load(PTR_SIG1, 0);
		#1 chk(lpmValid, 1'b0);
		cmd(PAT_LOAD, 16'h0002, 16'hAAAA, 4);
		slot_chk(7'h01, ERASED_WORD);
		cmd(PAT_LOAD, 16'h0006, 16'h5555, 0);
		eepromBusy <= 1'b1;
		slot_chk(7'h03, ERASED_WORD);
		wr(A_CTRL, {26'h0, PAT_ERASE});
		rd_chk(A_CTRL, 32'h1, 32'h0);
		wr(A_CTRL, {26'h0, PAT_LOCK});
		cpu.load(PTR_FUSE_LOW, 0);
		#1 chk(lpmValid, 1'b0);
		eepromBusy <= 1'b0;
		rd_chk(32'h08, 32'hFFFFFFFF, 32'h0);
	endtask
	// interrupt raised while idle, dropped while running, masked
	task automatic t_irq();
		ie = 1'b1;
		wr(A_CTRL, 32'h80);
		tick(2);
		#1 chk(spmIrq, 1'b1);
		cmd(PAT_ERASE, 16'h0500, 16'h0, 0);
		#1 chk(spmIrq, 1'b0);
		wait_idle();
		tick(1);
		#1 chk(spmIrq, 1'b1);
		cmd(PAT_REEN, 16'h0, 16'h0, 0);
		ie = 1'b0;
		wr(A_CTRL, 32'h0);
		tick(2);
		#1 chk(spmIrq, 1'b0);
	endtask
	// main sequence
	initial begin
		tick(12);
		reset_n <= 1'b1;
		tick(1);
		t_erase_halt();
		t_write();
		t_lock_read();
		t_refuse();
		t_irq();
		report_and_stop();
	end
endmodule
`default_nettype wire
